/* File: inc/pwt_pkg.sv */
// Constants, register map and divide table of the periodic wakeup timer.
`default_nettype none

package pwt_pkg;

  // ----------------------------------------------------------------------
  // Bus and datapath widths.
  // ----------------------------------------------------------------------
  localparam int unsigned WB_AW = 8;
  localparam int unsigned WB_DW = 32;
  localparam int unsigned DIV_W = 18;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned EVT_W = 2;
  localparam int unsigned SRC_N = 3;

  // ----------------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------------
  localparam logic [WB_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [WB_AW-1:0] OFS_MOD  = 8'h04;
  localparam logic [WB_AW-1:0] OFS_CNT  = 8'h08;
  localparam logic [WB_AW-1:0] OFS_EVT  = 8'h0c;
  localparam logic [WB_AW-1:0] OFS_MSK  = 8'h10;

  // ----------------------------------------------------------------------
  // Fields of periodic_status_control.
  // ----------------------------------------------------------------------
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned SRC_HI   = 6;
  localparam int unsigned SRC_LO   = 5;
  localparam int unsigned IE_BIT   = 4;
  localparam int unsigned PS_HI    = 3;
  localparam int unsigned PS_LO    = 0;

  // Event status bits.
  localparam int unsigned EVT_MATCH   = 0;
  localparam int unsigned EVT_RESTART = 1;

  // ----------------------------------------------------------------------
  // Reset values and source codes.
  // ----------------------------------------------------------------------
  localparam logic [1:0]       SRC_RST  = 2'h0;
  localparam logic [3:0]       PS_RST   = 4'h0;
  localparam logic [CNT_W-1:0] MOD_RST  = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RST  = 2'h0;
  localparam logic [1:0]       SRC_LPO  = 2'h0;
  localparam logic [1:0]       SRC_EXT  = 2'h1;
  localparam logic [3:0]       PS_OFF   = 4'h0;

  // Divide ratio for a divider code; zero means the prescaler is off.
  function automatic logic [DIV_W-1:0] divide_ratio(
    input logic       hi_range,
    input logic [3:0] ps
  );
    logic [DIV_W-1:0] r;
    r = 18'h00000;
    case ({hi_range, ps})
      5'h01: r = 18'h00008;
      5'h02: r = 18'h00020;
      5'h03: r = 18'h00040;
      5'h04: r = 18'h00080;
      5'h05: r = 18'h00100;
      5'h06: r = 18'h00200;
      5'h07: r = 18'h00400;
      5'h08: r = 18'h00001;
      5'h09: r = 18'h00002;
      5'h0a: r = 18'h00004;
      5'h0b: r = 18'h0000a;
      5'h0c: r = 18'h00010;
      5'h0d: r = 18'h00064;
      5'h0e: r = 18'h001f4;
      5'h0f: r = 18'h003e8;
      5'h11: r = 18'h00400;
      5'h12: r = 18'h00800;
      5'h13: r = 18'h01000;
      5'h14: r = 18'h02000;
      5'h15: r = 18'h04000;
      5'h16: r = 18'h08000;
      5'h17: r = 18'h10000;
      5'h18: r = 18'h003e8;
      5'h19: r = 18'h007d0;
      5'h1a: r = 18'h01388;
      5'h1b: r = 18'h02710;
      5'h1c: r = 18'h04e20;
      5'h1d: r = 18'h0c350;
      5'h1e: r = 18'h186a0;
      5'h1f: r = 18'h30d40;
      default: r = 18'h00000;
    endcase
    return r;
  endfunction

endpackage

`default_nettype wire

/* File: inc/pwt_presc_if.sv */
// Link between the timer control logic and its prescaler.
`default_nettype none

interface pwt_presc_if;
  import pwt_pkg::*;

  logic             src_tick;
  logic             clear;
  logic [DIV_W-1:0] ratio;
  logic             tick_out;

  // Control side drives the source ticks, ratio and clear.
  modport ctl (output src_tick, output clear, output ratio, input tick_out);
  // Divider side counts source ticks and returns one tick per period.
  modport div (input src_tick, input clear, input ratio, output tick_out);
endinterface

`default_nettype wire

/* File: src/pwt_prescaler.sv */
// Prescaler that divides selected source ticks by a programmable ratio.
`default_nettype none

module pwt_prescaler (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control link.
  pwt_presc_if.div  pif
);
  import pwt_pkg::*;

  logic [DIV_W-1:0] count_ff;
  logic             tick_ff;

  // ----------------------------------------------------------------------
  // Divider.
  // ----------------------------------------------------------------------

  // A zero ratio holds the divider idle so it draws no toggling.
  always_ff @(posedge clk_i) begin
    if (rst_i || pif.clear || (pif.ratio == '0)) begin
      count_ff <= '0;
      tick_ff  <= 1'b0;
    end else if (pif.src_tick) begin
      if (count_ff == pif.ratio - 18'h00001) begin
        count_ff <= '0;
        tick_ff  <= 1'b1;
      end else begin
        count_ff <= count_ff + 18'h00001;
        tick_ff  <= 1'b0;
      end
    end else begin
      tick_ff <= 1'b0;
    end
  end

  assign pif.tick_out = tick_ff;

endmodule

`default_nettype wire

/* File: src/pwt_timer.sv */
// Periodic wakeup timer: control register, counter and interrupt logic.
//
// Decided for this implementation: the Wishbone register port and the address map.
`default_nettype none

// Operation
// - Set the match flag when the counter reaches the modulo value; here it sets on the next tick, as the counter wraps to zero.
// - Writing one clears flag and request; writing zero does nothing.
// - Reset clears flag, source select, interrupt enable and divider select.
// - Source 00 is the 1 kHz oscillator, 01 external, 1x internal.
// - Changing source select clears prescaler and counter.
// - With enable set, request is raised while the flag is set.
// - Divider select is four low bits; zero turns the prescaler off.
// - Changing divider select clears prescaler and counter.
// - Source low bit zero gives the binary and small decimal ratios.
// - Source low bit one gives the large binary and decimal ratios.
module pwt_timer (
  // Clock and reset.
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Wishbone slave.
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [pwt_pkg::WB_AW-1:0]  wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [pwt_pkg::WB_DW-1:0]  wb_dat_i,
  output logic      [pwt_pkg::WB_DW-1:0]  wb_dat_o,
  output logic                            wb_ack_o,
  // Tick sources, slow levels sampled on clk_i.
  input  wire logic                       low_power_1khz_oscillator_i,
  input  wire logic                       external_reference_clock_i,
  input  wire logic                       internal_reference_clock_i,
  // Interrupt.
  output logic                            irq_o
);
  import pwt_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  pwt_presc_if pif ();

  logic             flag_ff;
  logic [1:0]       src_ff;
  logic             ie_ff;
  logic [3:0]       ps_ff;
  logic [CNT_W-1:0] mod_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [EVT_W-1:0] evt_ff;
  logic [EVT_W-1:0] msk_ff;
  logic             ack_ff;
  logic [WB_DW-1:0] rdat_ff;
  logic             irq_ff;
  logic [SRC_N-1:0] src_lvl;
  logic [SRC_N-1:0] src_prev_ff;
  logic [SRC_N-1:0] src_rise;
  logic             wr_en;
  logic             wr_ctrl;
  logic             wr_mod;
  logic             wr_evt;
  logic             wr_msk;
  logic             restart;
  logic             match_evt;
  logic             flag_clr;
  logic [EVT_W-1:0] nxt_evt;
  logic [WB_DW-1:0] nxt_rdat;

  // Address decode shared by the write strobes and the read mux.
  function automatic logic hit(
    input logic [WB_AW-1:0] adr,
    input logic [WB_AW-1:0] ofs
  );
    return adr == ofs;
  endfunction

  // ----------------------------------------------------------------------
  // Wishbone slave.
  // ----------------------------------------------------------------------

  // Ack comes one cycle after the request and falls the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
    end
  end

  // Writes land on the edge where the master samples ack, as it expects.
  // Only byte lane 0 carries register data; other lanes are ignored.
  assign wr_en   = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && wb_sel_i[0];
  assign wr_ctrl = wr_en && hit(wb_adr_i, OFS_CTRL);
  assign wr_mod  = wr_en && hit(wb_adr_i, OFS_MOD);
  assign wr_evt  = wr_en && hit(wb_adr_i, OFS_EVT);
  assign wr_msk  = wr_en && hit(wb_adr_i, OFS_MSK);

  // Read mux; unmapped offsets answer with zero.
  always_comb begin
    nxt_rdat = '0;
    if (hit(wb_adr_i, OFS_CTRL)) begin
      nxt_rdat[7:0] = {flag_ff, src_ff, ie_ff, ps_ff};
    end else if (hit(wb_adr_i, OFS_MOD)) begin
      nxt_rdat[CNT_W-1:0] = mod_ff;
    end else if (hit(wb_adr_i, OFS_CNT)) begin
      nxt_rdat[CNT_W-1:0] = cnt_ff;
    end else if (hit(wb_adr_i, OFS_EVT)) begin
      nxt_rdat[EVT_W-1:0] = evt_ff;
    end else if (hit(wb_adr_i, OFS_MSK)) begin
      nxt_rdat[EVT_W-1:0] = msk_ff;
    end
  end

  // Read data is captured with the ack so both change on one edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= '0;
    end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      rdat_ff <= nxt_rdat;
    end
  end

  // ----------------------------------------------------------------------
  // Control register.
  // ----------------------------------------------------------------------

  // A write that alters source or divider restarts the whole count chain.
  assign restart = wr_ctrl &&
                   ((wb_dat_i[SRC_HI:SRC_LO] != src_ff) ||
                    (wb_dat_i[PS_HI:PS_LO] != ps_ff));
  assign flag_clr = wr_ctrl && wb_dat_i[FLAG_BIT];

  // Configuration fields of the control register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_ff <= SRC_RST;
      ie_ff  <= 1'b0;
      ps_ff  <= PS_RST;
    end else if (wr_ctrl) begin
      src_ff <= wb_dat_i[SRC_HI:SRC_LO];
      ie_ff  <= wb_dat_i[IE_BIT];
      ps_ff  <= wb_dat_i[PS_HI:PS_LO];
    end
  end

  // Modulo value, written whole through lane 0.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_ff <= MOD_RST;
    end else if (wr_mod) begin
      mod_ff <= wb_dat_i[CNT_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Source selection and prescaler.
  // ----------------------------------------------------------------------
  assign src_lvl = {internal_reference_clock_i,
                    external_reference_clock_i,
                    low_power_1khz_oscillator_i};

  // Rising edges of each source; sources must be well below clk_i.
  for (genvar g = 0; g < SRC_N; g++) begin : g_edge
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        src_prev_ff[g] <= 1'b0;
      end else begin
        src_prev_ff[g] <= src_lvl[g];
      end
    end
    assign src_rise[g] = src_lvl[g] && !src_prev_ff[g];
  end

  // Upper source bit wins, so both 1x codes pick the internal clock.
  assign pif.src_tick = src_ff[1] ? src_rise[2] :
                        (src_ff == SRC_EXT) ? src_rise[1] : src_rise[0];
  assign pif.ratio = divide_ratio(src_ff[0], ps_ff);
  assign pif.clear = restart;

  pwt_prescaler u_presc (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pif   (pif.div)
  );

  // ----------------------------------------------------------------------
  // Periodic counter and match flag.
  // ----------------------------------------------------------------------
  assign match_evt = pif.tick_out && (cnt_ff == mod_ff) && !restart;

  // A restart drops any tick in flight so the new setting starts clean.
  always_ff @(posedge clk_i) begin
    if (rst_i || restart) begin
      cnt_ff <= '0;
    end else if (pif.tick_out) begin
      cnt_ff <= (cnt_ff == mod_ff) ? '0 : cnt_ff + 8'h01;
    end
  end

  // A match in the cycle of a clearing write still sets the flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= 1'b0;
    end else if (match_evt) begin
      flag_ff <= 1'b1;
    end else if (flag_clr) begin
      flag_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Event status, mask and interrupt.
  // ----------------------------------------------------------------------

  // Sticky events; a write of one clears, a new event wins over it.
  always_comb begin
    nxt_evt = evt_ff;
    if (wr_evt) begin
      nxt_evt = nxt_evt & ~wb_dat_i[EVT_W-1:0];
    end
    nxt_evt[EVT_MATCH]   = nxt_evt[EVT_MATCH] | match_evt;
    nxt_evt[EVT_RESTART] = nxt_evt[EVT_RESTART] | restart;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_ff <= EVT_RST;
      msk_ff <= EVT_RST;
    end else begin
      evt_ff <= nxt_evt;
      if (wr_msk) begin
        msk_ff <= wb_dat_i[EVT_W-1:0];
      end
    end
  end

  // Registered so irq_o is glitch free; it trails the flag by one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (flag_ff && ie_ff) || |(evt_ff & msk_ff);
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign irq_o    = irq_ff;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  flag_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pif.tick_out && cnt_ff == mod_ff && !restart) |=> flag_ff)
    else $error("Match flag did not set at modulo.");

  flag_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (flag_clr && !match_evt) |=>
      !flag_ff ##1 (!irq_o || $past(|(evt_ff & msk_ff))))
    else $error("Writing one did not clear flag and request.");

  flag_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && !wb_dat_i[FLAG_BIT] && flag_ff) |=> flag_ff)
    else $error("Writing zero disturbed the match flag.");

  reset_fields_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> (!flag_ff && src_ff == SRC_RST && !ie_ff &&
                      ps_ff == PS_RST && !irq_o))
    else $error("Control fields not cleared by reset.");

  lpo_only_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (src_ff == SRC_LPO && !src_rise[0]) |-> !pif.src_tick)
    else $error("Tick taken from an unselected source.");

  restart_clr_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    restart |=> (cnt_ff == '0 && !pif.tick_out))
    else $error("Setting change did not clear the count chain.");

  irq_level_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (flag_ff && ie_ff) |=> irq_o)
    else $error("Enabled flag did not raise the interrupt.");

  irq_quiet_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!ie_ff && (evt_ff & msk_ff) == '0) |=> !irq_o)
    else $error("Interrupt raised with nothing enabled.");

  div_off_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ps_ff == PS_OFF && $past(ps_ff) == PS_OFF) |-> !pif.tick_out)
    else $error("Prescaler ticked while switched off.");

  ratio_one_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pif.src_tick && !src_ff[0] && ps_ff == 4'h8 && !restart &&
     $past(ps_ff) == 4'h8 && $past(src_ff) == src_ff) |=> pif.tick_out)
    else $error("Divide by one did not pass every tick.");

  ratio_hi_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (src_ff[0] && ps_ff != PS_OFF) |-> pif.ratio >= 18'h003e8)
    else $error("Large-range ratio below one thousand.");

  wrap_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pif.tick_out && cnt_ff == mod_ff) |=> cnt_ff == '0)
    else $error("Counter did not wrap at modulo.");

  ack_pulse_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("Ack held longer than one cycle.");

endmodule

`default_nettype wire

/* File: tb/pwt_timer_bench.sv */
// Self-checking bench for the periodic wakeup timer over Wishbone.
`default_nettype none

module pwt_timer_bench import pwt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // Signals and design under test.
  // ----------------------------------------------------------------------
  localparam int LIMIT = 40000;
  logic                clk_i;
  logic                rst_i;
  logic                cyc;
  logic                stb;
  logic                we;
  logic [WB_AW-1:0]    adr;
  logic [WB_DW-1:0]    wdat;
  logic [3:0]          sel;
  logic [3:0]          lanes;
  logic [WB_DW-1:0]    wb_dat_o;
  logic                wb_ack_o;
  logic [2:0]          src;
  logic                irq_o;
  int                  fails;
  int                  comparisons;
  int                  cycles;
  logic [WB_DW-1:0]    d;

  pwt_timer pwt_timer_i (
    .clk_i                       (clk_i),
    .rst_i                       (rst_i),
    .wb_cyc_i                    (cyc),
    .wb_stb_i                    (stb),
    .wb_we_i                     (we),
    .wb_adr_i                    (adr),
    .wb_sel_i                    (sel),
    .wb_dat_i                    (wdat),
    .wb_dat_o                    (wb_dat_o),
    .wb_ack_o                    (wb_ack_o),
    .low_power_1khz_oscillator_i (src[0]),
    .external_reference_clock_i  (src[1]),
    .internal_reference_clock_i  (src[2]),
    .irq_o                       (irq_o)
  );

  // Free-running 20 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------------
  // Reporting and watchdog.
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A hung handshake would stall forever, so the cycle count caps the run.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------
  // Bus and source drivers.
  // ----------------------------------------------------------------------
  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb_io(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= lanes;
    adr  <= a;
    wdat <= wd;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
  endtask

  task automatic wb_wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    wb_io(1'b1, a, wd, dummy);
  endtask

  // Each source edge lasts one clock high and one low, then ticks settle.
  task automatic pulse(input int pin, input int n);
    repeat (n) begin
      @(posedge clk_i) src[pin] <= 1'b1;
      @(posedge clk_i) src[pin] <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
  endtask

  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge clk_i);
    check("irq", {31'h0, irq_o}, {31'h0, exp});
  endtask

  // Selecting a source and divider restarts the count; ratio-1 edges on
  // the chosen pin and some on another pin must not yet advance it.
  task automatic run_ratio(input logic [1:0] s, input logic [3:0] ps,
                           input int ratio, input int pin);
    logic [31:0] r;
    wb_wr(OFS_CTRL, {24'h0, 1'b0, s, 1'b0, ps});
    wb_io(1'b0, OFS_CNT, 32'h0, r);
    check("cnt after select", r, 32'h0);
    pulse(pin, ratio - 1);
    pulse((pin + 1) % 3, 2);
    wb_io(1'b0, OFS_CNT, 32'h0, r);
    check("cnt before tick", r, 32'h0);
    pulse(pin, 1);
    wb_io(1'b0, OFS_CNT, 32'h0, r);
    check("cnt after tick", r, 32'h1);
  endtask

  // ----------------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'h0;
    lanes = 4'hf;
    src = 3'h0;
    fails = 0;
    comparisons = 0;
    cycles = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // Every register and an unmapped place read zero after reset.
    foreach (d[i]) begin
      if (i < 6) begin
        wb_io(1'b0, (i == 5) ? 8'h40 : 8'(i * 4), 32'h0, d);
        check("reset value", d, 32'h0);
      end
    end
    chk_irq(1'b0);
    // Divide by one from the oscillator, modulo two, interrupt on.
    wb_wr(OFS_MOD, 32'h2);
    wb_wr(OFS_CTRL, 32'h18);
    wb_wr(OFS_EVT, 32'h3);
    pulse(0, 2);
    wb_io(1'b0, OFS_CNT, 32'h0, d);
    check("cnt two", d, 32'h2);
    wb_io(1'b0, OFS_CTRL, 32'h0, d);
    check("flag low", d, 32'h18);
    chk_irq(1'b0);
    pulse(0, 1);
    wb_io(1'b0, OFS_CNT, 32'h0, d);
    check("cnt wrap", d, 32'h0);
    wb_io(1'b0, OFS_CTRL, 32'h0, d);
    check("flag set", d, 32'h98);
    chk_irq(1'b1);
    // Writing zero keeps the flag; with the enable off no request shows.
    wb_wr(OFS_CTRL, 32'h08);
    wb_io(1'b0, OFS_CTRL, 32'h0, d);
    check("flag kept", d, 32'h88);
    chk_irq(1'b0);
    wb_wr(OFS_CTRL, 32'h18);
    chk_irq(1'b1);
    wb_wr(OFS_CTRL, 32'h98);
    wb_io(1'b0, OFS_CTRL, 32'h0, d);
    check("flag cleared", d, 32'h18);
    chk_irq(1'b0);
    // Divider change clears a running count and flags a restart event.
    pulse(0, 1);
    wb_wr(OFS_EVT, 32'h3);
    wb_wr(OFS_MSK, 32'h2);
    wb_wr(OFS_CTRL, 32'h19);
    wb_io(1'b0, OFS_CNT, 32'h0, d);
    check("cnt cleared", d, 32'h0);
    wb_io(1'b0, OFS_EVT, 32'h0, d);
    check("restart event", d, 32'h2);
    chk_irq(1'b1);
    wb_wr(OFS_EVT, 32'h2);
    chk_irq(1'b0);
    pulse(0, 3);
    wb_io(1'b0, OFS_CNT, 32'h0, d);
    check("divide by two", d, 32'h1);
    wb_wr(OFS_CNT, 32'h55);
    wb_io(1'b0, OFS_CNT, 32'h0, d);
    check("cnt read only", d, 32'h1);
    // A write without byte lane 0 must leave the modulo untouched.
    lanes = 4'he;
    wb_wr(OFS_MOD, 32'h7);
    lanes = 4'hf;
    wb_io(1'b0, OFS_MOD, 32'h0, d);
    check("lane zero off", d, 32'h2);
    // Source and divider table entries from each range.
    run_ratio(2'h0, 4'h1, 8, 0);
    run_ratio(2'h0, 4'hf, 1000, 0);
    run_ratio(2'h1, 4'h8, 1000, 1);
    run_ratio(2'h1, 4'h1, 1024, 1);
    run_ratio(2'h2, 4'hb, 10, 2);
    run_ratio(2'h3, 4'h8, 1000, 2);
    // Divider value zero stops counting altogether.
    wb_wr(OFS_CTRL, 32'h00);
    pulse(0, 20);
    wb_io(1'b0, OFS_CNT, 32'h0, d);
    check("divider off", d, 32'h0);
    report_and_stop();
  end

endmodule

`default_nettype wire
